/* hdl/bcd_pkg.sv */
// package: offsets, field layouts, reset values and types of the bcd datapath
package bcd_pkg;
	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_SRC    = 8'h04;
	localparam logic [7:0] OFS_ACC_LO = 8'h08;
	localparam logic [7:0] OFS_ACC_HI = 8'h0c;
	localparam logic [7:0] OFS_DEST   = 8'h10;
	localparam logic [7:0] OFS_FLAGS  = 8'h14;
	// command fields
	localparam int CMD_OP_BIT  = 0;
	localparam int CMD_SEL_BIT = 1;
	// flag fields
	localparam int FLG_MINOR_BIT = 4;
	localparam int FLG_BUSY_BIT  = 5;
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	// conversion limits
	localparam logic [31:0] BIN_MAX   = 32'h0000_7fff;
	localparam logic [3:0]  DIGIT_MAX = 4'h9;
	localparam logic [15:0] BCD4_MAX  = 16'h270f;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		BCD_ST_IDLE = 2'b00,
		BCD_ST_EXEC = 2'b01
	} bcd_state_e;

	typedef enum logic {
		BCD_OP_CONVERT = 1'b0,
		BCD_OP_DECODE  = 1'b1
	} bcd_op_e;

	// arithmetic status bits, high bit first
	typedef struct packed {
		logic minor;
		logic sign;
		logic zero;
		logic ovf;
		logic carry;
	} bcd_flags_s;
endpackage

/* hdl/bcd_datapath.sv */
// bcd-to-integer conversion and nibble decode datapath, axi4-lite slave
//
// Behaviour
// - convert op reads source as bcd digits, writes binary integer to dest
// - convert source is data word or both accumulator words; dest is the destination word
// - overflow set on any non-bcd digit or value above 32767, else cleared
// - every conversion overflow also sets the sticky minor-error flag
// - zero flag set when a conversion leaves destination zero, cleared by any other conversion
// - values above 9999 convert only from the accumulator, high word leads
// - accumulator high word always enters as leading digits
// - decode op turns on exactly one bit of the 16-bit destination
// - decoded bit position equals low four bits of the selected word (data word or accumulator low word)
// - accumulator holds a five-digit bcd value across its two words
`timescale 1ns/1ns
module bcd_datapath (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	bcd_pkg::bcd_state_e state_r;
	bcd_pkg::bcd_op_e    op_r;
	bcd_pkg::bcd_flags_s flags_r;
	logic        sel_acc_r;
	logic [15:0] src_r;
	logic [15:0] acc_lo_r;
	logic [15:0] acc_hi_r;
	logic [15:0] dest_r;
	logic [7:0]  awaddr_r;
	logic        aw_full_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        w_full_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [1:0]  rresp_r;
	logic [31:0] rdata_r;
	logic        wr_go;
	logic        cmd_go;
	logic        exec;
	logic        minor_clr;
	logic [31:0] cvt_src;
	logic [31:0] cvt_val;
	logic [3:0]  nib;
	logic        cvt_bad;
	logic        cvt_ovf;
	logic [15:0] dec_val;
	logic [15:0] wr_word;

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_full_r && !bvalid_r;
	assign s_axi_wready  = !w_full_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign wr_go  = aw_full_r && w_full_r;
	assign cmd_go = wr_go && awaddr_r == bcd_pkg::OFS_CMD
		&& state_r == bcd_pkg::BCD_ST_IDLE;
	assign minor_clr = wr_go && awaddr_r == bcd_pkg::OFS_FLAGS
		&& wstrb_r[0] && wdata_r[bcd_pkg::FLG_MINOR_BIT];
	// only the low 16 bits hold data; upper lanes ignored
	assign wr_word = {wstrb_r[1] ? wdata_r[15:8] : 8'h00,
		wstrb_r[0] ? wdata_r[7:0] : 8'h00};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			awaddr_r  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_r <= 1'b0;
		end
	end

	// response follows both halves; unmapped or read-only address errors
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= bcd_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			case (awaddr_r)
				bcd_pkg::OFS_CMD, bcd_pkg::OFS_SRC, bcd_pkg::OFS_ACC_LO,
				bcd_pkg::OFS_ACC_HI, bcd_pkg::OFS_FLAGS:
					bresp_r <= bcd_pkg::RESP_OKAY;
				default:
					bresp_r <= bcd_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// operand words; accumulator spans two words for five digits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_r    <= bcd_pkg::RST_WORD;
			acc_lo_r <= bcd_pkg::RST_WORD;
			acc_hi_r <= bcd_pkg::RST_WORD;
		end else if (wr_go) begin
			case (awaddr_r)
				bcd_pkg::OFS_SRC:    src_r    <= wr_word;
				bcd_pkg::OFS_ACC_LO: acc_lo_r <= wr_word;
				bcd_pkg::OFS_ACC_HI: acc_hi_r <= wr_word;
				default:             src_r    <= src_r;
			endcase
		end
	end

	// command latch: commands while busy are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_r      <= bcd_pkg::BCD_OP_CONVERT;
			sel_acc_r <= 1'b0;
		end else if (cmd_go) begin
			op_r      <= bcd_pkg::bcd_op_e'(wdata_r[bcd_pkg::CMD_OP_BIT]);
			sel_acc_r <= wdata_r[bcd_pkg::CMD_SEL_BIT];
		end
	end

	// sequencer: one cycle to execute after the command lands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= bcd_pkg::BCD_ST_IDLE;
		end else begin
			case (state_r)
				bcd_pkg::BCD_ST_IDLE:
					if (cmd_go) state_r <= bcd_pkg::BCD_ST_EXEC;
				bcd_pkg::BCD_ST_EXEC:
					state_r <= bcd_pkg::BCD_ST_IDLE;
				default:
					state_r <= bcd_pkg::BCD_ST_IDLE;
			endcase
		end
	end
	assign exec = state_r == bcd_pkg::BCD_ST_EXEC;

	// source pick; high word joins only from the accumulator
	assign cvt_src = sel_acc_r ? {acc_hi_r, acc_lo_r}
		: {16'h0000, src_r};

	// digit walk, most significant first; stale high digits count too
	always_comb begin
		cvt_bad = 1'b0;
		cvt_val = 32'h0000_0000;
		nib     = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			nib = cvt_src[i*4 +: 4];
			if (nib > bcd_pkg::DIGIT_MAX)
				cvt_bad = 1'b1;
			cvt_val = 32'(cvt_val * 32'd10) + {28'h000_0000, nib};
		end
	end
	// eight digits fit 32 bits, so the range test cannot wrap
	assign cvt_ovf = cvt_bad || cvt_val > bcd_pkg::BIN_MAX;

	// one-hot from the low nibble of the selected word
	assign dec_val = 16'h0001 << cvt_src[3:0];

	// destination word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dest_r <= bcd_pkg::RST_WORD;
		end else if (exec) begin
			if (op_r == bcd_pkg::BCD_OP_DECODE)
				dest_r <= dec_val;
			else
				dest_r <= cvt_val[15:0];
		end
	end

	// status flags; decode leaves them alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= '0;
		end else begin
			if (exec && op_r == bcd_pkg::BCD_OP_CONVERT) begin
				flags_r.carry <= 1'b0;
				flags_r.sign  <= 1'b0;
				flags_r.ovf   <= cvt_ovf;
				flags_r.zero  <= cvt_val[15:0] == 16'h0000;
			end
			// set beats a clear in the same cycle
			flags_r.minor <= (flags_r.minor && !minor_clr)
				|| (exec && op_r == bcd_pkg::BCD_OP_CONVERT
				&& cvt_ovf);
		end
	end

	// read channel: one outstanding read
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= bcd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= bcd_pkg::RESP_OKAY;
			case (s_axi_araddr)
				bcd_pkg::OFS_CMD: rdata_r <= {30'h0000_0000,
					sel_acc_r, op_r};
				bcd_pkg::OFS_SRC:    rdata_r <= {16'h0000, src_r};
				bcd_pkg::OFS_ACC_LO: rdata_r <= {16'h0000, acc_lo_r};
				bcd_pkg::OFS_ACC_HI: rdata_r <= {16'h0000, acc_hi_r};
				bcd_pkg::OFS_DEST:   rdata_r <= {16'h0000, dest_r};
				bcd_pkg::OFS_FLAGS:  rdata_r <= {26'h000_0000, exec,
					flags_r};
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= bcd_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_cmd;
		cmd_go;
	endsequence
	sequence s_run;
		exec ##1 !exec;
	endsequence
	sequence s_cvt;
		exec && op_r == bcd_pkg::BCD_OP_CONVERT;
	endsequence
	sequence s_dec;
		exec && op_r == bcd_pkg::BCD_OP_DECODE;
	endsequence

	property p_cmd_run;
		s_cmd |=> s_run;
	endproperty
	a_cmd_run: assert property (p_cmd_run)
		else $error("command did not execute in one cycle");

	property p_cvt_dest;
		s_cvt and !cvt_ovf |=> dest_r == $past(cvt_val[15:0])
			&& dest_r <= 16'(bcd_pkg::BIN_MAX);
	endproperty
	a_cvt_dest: assert property (p_cvt_dest)
		else $error("conversion result wrong");

	property p_word_src;
		s_cvt and !sel_acc_r |=> dest_r <= bcd_pkg::BCD4_MAX
			|| flags_r.ovf;
	endproperty
	a_word_src: assert property (p_word_src)
		else $error("data word gave more than four digits");

	property p_ovf;
		s_cvt |=> flags_r.ovf == $past(cvt_bad
			|| cvt_val > bcd_pkg::BIN_MAX);
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow flag wrong");

	property p_minor;
		s_cvt and cvt_ovf |=> flags_r.minor && flags_r.ovf;
	endproperty
	a_minor: assert property (p_minor)
		else $error("minor error not set on overflow");

	property p_zero;
		s_cvt |=> flags_r.zero == (dest_r == 16'h0000);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag disagrees with destination");

	property p_high_digits;
		s_cvt and sel_acc_r and acc_hi_r[15:4] != 12'h000
			|=> flags_r.ovf;
	endproperty
	a_high_digits: assert property (p_high_digits)
		else $error("upper accumulator digits ignored");

	property p_onehot;
		s_dec |=> $onehot(dest_r);
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("decode result not one-hot");

	property p_dec_pos;
		s_dec |=> dest_r[$past(cvt_src[3:0])];
	endproperty
	a_dec_pos: assert property (p_dec_pos)
		else $error("decode bit position wrong");

	property p_cs_clear;
		s_cvt |=> !flags_r.carry && !flags_r.sign;
	endproperty
	a_cs_clear: assert property (p_cs_clear)
		else $error("carry or sign left set");

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
endmodule

/* tb/bcd_seq_model.sv */
// sequencer model: axi4-lite master issuing operands and commands
`timescale 1ns/1ns
module bcd_seq_model (
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	// idle bus from time zero
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end
	// readies sampled at the falling edge, stable until the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge aclk);
			pa = pa && !ta;
			pw = pw && !tw;
			awvalid <= pa;
			wvalid <= pw;
		end
		// released payload must not look like a live one
		awaddr <= ~a;
		wdata <= ~d;
		ta = 1'b0;
		while (!ta) begin
			@(negedge aclk);
			ta = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		// idle edge so a following call never re-raises bready at once
		@(posedge aclk);
	endtask
	// byte enables for the next writes, changed only between transfers
	task automatic strb(input logic [3:0] s);
		wstrb <= s;
		@(posedge aclk);
	endtask
	// read: hold address until taken, rready until data seen
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		logic t;
		t = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!t) begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		araddr <= ~a;
		t = 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		// idle edge so back-to-back reads keep one assignment per step
		@(posedge aclk);
	endtask
endmodule

/* tb/bcd_to_binary_and_bit_decode_tb.sv */
// self-checking bench for the bcd conversion and decode datapath
`timescale 1ns/1ns
module bcd_to_binary_and_bit_decode_tb;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          err_total, comparisons, cyc;

	bcd_datapath DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	bcd_seq_model seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// start an op, then poll busy with a bound
	task automatic op(input logic [1:0] c);
		int k;
		k = 0;
		seq.wr(bcd_pkg::OFS_CMD, {30'h0, c}, r);
		do begin
			seq.rd(bcd_pkg::OFS_FLAGS, v, r);
			k++;
		end while (v[bcd_pkg::FLG_BUSY_BIT] && k < 20);
		// a poll that ran out, or an unknown busy bit, is a mismatch
		chk("busy", 32'h0000_0000, {31'h0, v[bcd_pkg::FLG_BUSY_BIT]});
	endtask
	// convert; dest unchecked and zero flag masked when dk is low
	task automatic cv(input logic sel, dk, input logic [31:0] d,
			input logic [4:0] f);
		op({sel, 1'b0});
		seq.rd(bcd_pkg::OFS_DEST, v, r);
		if (dk) chk("dest", d, v);
		seq.rd(bcd_pkg::OFS_FLAGS, v, r);
		chk("flags", {27'h0, f}, v & (dk ? 32'h0000_001f : 32'h0000_001b));
	endtask
	task automatic t_regs();
		seq.rd(bcd_pkg::OFS_FLAGS, v, r);
		chk("flags rst", 32'h0000_0000, v);
		seq.rd(bcd_pkg::OFS_DEST, v, r);
		chk("dest rst", 32'h0000_0000, v);
		seq.rd(8'h18, v, r);
		chk("unmapped rresp", {30'h0, bcd_pkg::RESP_SLVERR}, {30'h0, r});
		seq.wr(bcd_pkg::OFS_DEST, 32'h0000_1111, r);
		chk("dest bresp", {30'h0, bcd_pkg::RESP_SLVERR}, {30'h0, r});
		// only lane 0 strobed: the upper byte lands as zero
		seq.strb(4'h1);
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_5678, r);
		seq.strb(4'hf);
		seq.rd(bcd_pkg::OFS_SRC, v, r);
		chk("src lane", 32'h0000_0078, v);
		$display("end t_regs");
	endtask
	task automatic t_word();
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_1234, r);
		// read back: source must read the same on two reads before converting
		seq.rd(bcd_pkg::OFS_SRC, v, r);
		chk("src scan1", 32'h0000_1234, v);
		seq.rd(bcd_pkg::OFS_SRC, v, r);
		chk("src scan2", 32'h0000_1234, v);
		cv(1'b0, 1'b1, 32'h0000_04d2, 5'h00);
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_0000, r);
		cv(1'b0, 1'b1, 32'h0000_0000, 5'h04);
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_9999, r);
		cv(1'b0, 1'b1, 32'h0000_270f, 5'h00);
		$display("end t_word");
	endtask
	// non-bcd digit, then sticky minor error survives a good conversion
	task automatic t_bad();
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_12a4, r);
		cv(1'b0, 1'b0, 32'h0, 5'h12);
		seq.wr(bcd_pkg::OFS_SRC, 32'h0000_0001, r);
		cv(1'b0, 1'b1, 32'h0000_0001, 5'h10);
		seq.wr(bcd_pkg::OFS_FLAGS, 32'h0000_0010, r);
		seq.rd(bcd_pkg::OFS_FLAGS, v, r);
		chk("minor clr", 32'h0000_0000, v);
		$display("end t_bad");
	endtask
	task automatic t_acc();
		seq.wr(bcd_pkg::OFS_ACC_HI, 32'h0000_0003, r);
		seq.wr(bcd_pkg::OFS_ACC_LO, 32'h0000_2767, r);
		cv(1'b1, 1'b1, 32'h0000_7fff, 5'h00);
		seq.wr(bcd_pkg::OFS_ACC_LO, 32'h0000_2768, r);
		cv(1'b1, 1'b0, 32'h0, 5'h12);
		seq.wr(bcd_pkg::OFS_FLAGS, 32'h0000_0010, r);
		seq.wr(bcd_pkg::OFS_ACC_HI, 32'h0000_0001, r);
		seq.wr(bcd_pkg::OFS_ACC_LO, 32'h0000_0005, r);
		cv(1'b1, 1'b1, 32'h0000_2715, 5'h00);
		seq.wr(bcd_pkg::OFS_ACC_HI, 32'h0000_0000, r);
		seq.wr(bcd_pkg::OFS_ACC_LO, 32'h0000_0042, r);
		cv(1'b1, 1'b1, 32'h0000_002a, 5'h00);
		$display("end t_acc");
	endtask
	// every nibble value, upper bits of source set to prove they are ignored
	task automatic t_dec();
		for (int i = 0; i < 16; i++) begin
			seq.wr(bcd_pkg::OFS_SRC, {16'h0, 12'habc, 4'(i)}, r);
			op(2'b01);
			seq.rd(bcd_pkg::OFS_DEST, v, r);
			chk("onehot", 32'h0000_0001 << i, v);
		end
		seq.wr(bcd_pkg::OFS_ACC_LO, 32'h0000_000f, r);
		op(2'b11);
		seq.rd(bcd_pkg::OFS_DEST, v, r);
		chk("onehot acc", 32'h0000_8000, v);
		$display("end t_dec");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	initial begin
		aresetn = 1'b0;
		err_total = 0;
		comparisons = 0;
		cyc = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_word();
		t_bad();
		t_acc();
		t_dec();
		results();
	end
endmodule
